// File: hdl/scs_pkg.sv
// Constants for the serial control-two and status register block
package scs_pkg;
  localparam logic [7:0]  SCS_OFS_CTRL2    = 8'h04;
  localparam logic [7:0]  SCS_OFS_STATUS   = 8'h08;
  localparam logic [7:0]  SCS_OFS_DATA     = 8'h0c;
  localparam logic [7:0]  SCS_OFS_IRQ_STS  = 8'h24;
  localparam logic [7:0]  SCS_OFS_IRQ_MASK = 8'h28;
  localparam logic [7:0]  SCS_OFS_CONFIG   = 8'h2c;
  localparam int          SCS_C2_RXDMA     = 0;
  localparam int          SCS_C2_TXDMA     = 1;
  localparam int          SCS_C2_SSOE      = 2;
  localparam int          SCS_C2_FRF       = 4;
  localparam int          SCS_C2_ERRIE     = 5;
  localparam int          SCS_C2_RXIE      = 6;
  localparam int          SCS_C2_TXIE      = 7;
  localparam int          SCS_ST_UDR       = 3;
  localparam int          SCS_ST_CRC       = 4;
  localparam int          SCS_ST_MF        = 5;
  localparam int          SCS_ST_OVR       = 6;
  localparam int          SCS_CF_MASTER    = 0;
  localparam int          SCS_CF_AUDIO     = 1;
  localparam int          SCS_CF_WIDE      = 2;
  localparam int          SCS_CF_PCM       = 3;
  localparam int          SCS_IRQ_RX       = 0;
  localparam int          SCS_IRQ_TX       = 1;
  localparam int          SCS_IRQ_ERR      = 2;
  localparam logic [15:0] SCS_CTRL2_RST    = 16'h0000;
  localparam logic [15:0] SCS_CTRL2_WMASK  = 16'h00f7;
  localparam logic [15:0] SCS_STATUS_RST   = 16'h0002;
  localparam logic [2:0]  SCS_IRQ_MASK_RST = 3'h7;
  localparam logic [3:0]  SCS_CONFIG_RST   = 4'h0;
  localparam logic [1:0]  SCS_RESP_OKAY    = 2'h0;
  localparam logic [1:0]  SCS_RESP_SLVERR  = 2'h2;
  localparam logic [4:0]  SCS_BITS_NARROW  = 5'h08;
  localparam logic [4:0]  SCS_BITS_WIDE    = 5'h10;
endpackage

// File: hdl/scs_top.sv
// Control-two and status registers with slave shift engine and AXI4-Lite access
//
// Design decision made here: the AXI4-Lite slave port.
`timescale 1ns/1ns
module scs_top
  import scs_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // AXI4-Lite write
  input  wire logic [7:0]  s_axi_awaddr_i,
  input  wire logic        s_axi_awvalid_i,
  output logic             s_axi_awready_o,
  input  wire logic [31:0] s_axi_wdata_i,
  input  wire logic [3:0]  s_axi_wstrb_i,
  input  wire logic        s_axi_wvalid_i,
  output logic             s_axi_wready_o,
  output logic [1:0]       s_axi_bresp_o,
  output logic             s_axi_bvalid_o,
  input  wire logic        s_axi_bready_i,
  // AXI4-Lite read
  input  wire logic [7:0]  s_axi_araddr_i,
  input  wire logic        s_axi_arvalid_i,
  output logic             s_axi_arready_o,
  output logic [31:0]      s_axi_rdata_o,
  output logic [1:0]       s_axi_rresp_o,
  output logic             s_axi_rvalid_o,
  input  wire logic        s_axi_rready_i,
  // Serial link
  input  wire logic        sck_i,
  input  wire logic        ss_n_i,
  output logic             ss_n_o,
  output logic             ss_n_oe_o,
  input  wire logic        mosi_i,
  output logic             miso_o,
  output logic             miso_oe_o,
  // Engine side
  input  wire logic        crc_mismatch_i,
  output logic             frame_format_o,
  output logic             rx_dma_req_o,
  output logic             tx_dma_req_o,
  output logic             irq_o
);
  import scs_pkg::*;

  function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] ofs);
    return addr[7:2] == ofs[7:2];
  endfunction

  logic [15:0] ctrl2_r;
  logic [3:0]  cfg_r;
  logic [2:0]  irq_mask_r;
  logic [2:0]  irq_sts_r;
  logic [15:0] txbuf_r;
  logic [15:0] rxbuf_r;
  logic        rxne_r, txe_r, udr_r, crc_r, mf_r, ovr_r, fre_r, side_r;
  logic [2:0]  sck_q, ss_q;
  logic [1:0]  mosi_q;
  logic        ws_last_r, active_r;
  logic [4:0]  bit_cnt_r;
  logic [15:0] rxsh_r, txsh_r;
  logic        aw_got_r, w_got_r;
  logic [7:0]  awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0]  wstrb_r;

  // Link synchronisers: stage 0 is read only by stage 1
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sck_q  <= 3'h0;
      ss_q   <= 3'h7;
      mosi_q <= 2'h0;
    end
    else
    begin
      sck_q  <= {sck_q[1:0], sck_i};
      ss_q   <= {ss_q[1:0], ss_n_i};
      mosi_q <= {mosi_q[0], mosi_i};
    end
  end

  logic       sck_rise, sck_fall, ss_lvl, ss_fall, mosi_lvl;
  logic       audio, master, pulse_mode, spi, ws_chg, start, shift_en, word_done, load, fre_evt;
  logic       wr_fire, rd_fire, data_wr, data_rd, sts_wr, sts_rd;
  logic [4:0] nbits;
  logic [15:0] rxsh_nxt;

  assign sck_rise = sck_q[1] & ~sck_q[2];
  assign sck_fall = ~sck_q[1] & sck_q[2];
  assign ss_lvl   = ss_q[1];
  assign ss_fall  = ~ss_q[1] & ss_q[2];
  assign mosi_lvl = mosi_q[1];
  assign audio    = cfg_r[SCS_CF_AUDIO];
  assign master   = cfg_r[SCS_CF_MASTER];
  assign pulse_mode = ctrl2_r[SCS_C2_FRF] & ~audio;
  assign spi      = ~pulse_mode & ~audio;
  assign nbits    = cfg_r[SCS_CF_WIDE] ? SCS_BITS_WIDE : SCS_BITS_NARROW;
  assign ws_chg   = sck_rise & audio & (ss_lvl != ws_last_r);
  // Frame start: select edge, frame pulse, or word-select change
  assign start    = ~master & (spi ? ss_fall :
                    (pulse_mode ? (sck_rise & ss_lvl & ~active_r) : ws_chg));
  assign shift_en = sck_rise & active_r & ~start;
  assign word_done = shift_en & (bit_cnt_r == nbits - 5'h01);
  assign load     = start | (word_done & spi & ~ss_lvl);
  assign rxsh_nxt = {rxsh_r[14:0], mosi_lvl};
  // Pulse or word select moving mid-word in a framed slave mode
  assign fre_evt  = ~master & ~spi & active_r & (bit_cnt_r != 5'h00) &
                    (pulse_mode ? (sck_rise & ss_lvl) : ws_chg);

  // Master clocking lives outside; this engine only runs as a slave
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      active_r  <= 1'b0;
      bit_cnt_r <= 5'h00;
      ws_last_r <= 1'b0;
      side_r    <= 1'b0;
      rxsh_r    <= 16'h0000;
      txsh_r    <= 16'h0000;
    end
    else
    begin
      if (sck_rise)
        ws_last_r <= ss_lvl;
      if (start & audio)
        side_r <= ss_lvl;
      if (start)
        active_r <= 1'b1;
      else if ((spi & ss_lvl) | master | (word_done & pulse_mode))
        active_r <= 1'b0;
      if (start | fre_evt | word_done | ~active_r)
        bit_cnt_r <= 5'h00;
      else if (shift_en)
        bit_cnt_r <= bit_cnt_r + 5'h01;
      if (shift_en)
        rxsh_r <= rxsh_nxt;
      // Narrow words sit in the top byte so bit 15 is always next out
      if (load)
        txsh_r <= cfg_r[SCS_CF_WIDE] ? txbuf_r : {txbuf_r[7:0], 8'h00};
      else if (sck_fall & active_r)
        txsh_r <= {txsh_r[14:0], 1'b0};
    end
  end

  assign miso_o    = txsh_r[15];
  assign miso_oe_o = ~master & active_r;
  assign ss_n_o    = 1'b0;
  assign ss_n_oe_o = master & ctrl2_r[SCS_C2_SSOE] & ~audio;
  assign frame_format_o = pulse_mode;

  // Buffers and flags; a hardware set always beats a software clear
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rxbuf_r <= 16'h0000;
      txbuf_r <= 16'h0000;
      rxne_r  <= SCS_STATUS_RST[0];
      txe_r   <= SCS_STATUS_RST[1];
      udr_r   <= 1'b0;
      crc_r   <= 1'b0;
      mf_r    <= 1'b0;
      ovr_r   <= 1'b0;
      fre_r   <= 1'b0;
    end
    else
    begin
      if (word_done & ~rxne_r)
        rxbuf_r <= cfg_r[SCS_CF_WIDE] ? rxsh_nxt : {8'h00, rxsh_nxt[7:0]};
      if (data_wr & wstrb_r[0])
        txbuf_r[7:0] <= wdata_r[7:0];
      if (data_wr & wstrb_r[1] & cfg_r[SCS_CF_WIDE])
        txbuf_r[15:8] <= wdata_r[15:8];
      if (word_done)
        rxne_r <= 1'b1;
      else if (data_rd)
        rxne_r <= 1'b0;
      if (load)
        txe_r <= 1'b1;
      else if (data_wr)
        txe_r <= 1'b0;
      if (load & txe_r & audio)
        udr_r <= 1'b1;
      else if (sts_wr & wstrb_r[0] & ~wdata_r[SCS_ST_UDR])
        udr_r <= 1'b0;
      if (crc_mismatch_i & ~audio)
        crc_r <= 1'b1;
      else if (sts_wr & wstrb_r[0] & ~wdata_r[SCS_ST_CRC])
        crc_r <= 1'b0;
      if (master & ~ctrl2_r[SCS_C2_SSOE] & ~audio & ~ss_lvl)
        mf_r <= 1'b1;
      else if (sts_wr & wstrb_r[0] & ~wdata_r[SCS_ST_MF])
        mf_r <= 1'b0;
      if (word_done & rxne_r)
        ovr_r <= 1'b1;
      else if (sts_wr & wstrb_r[0] & ~wdata_r[SCS_ST_OVR])
        ovr_r <= 1'b0;
      if (fre_evt)
        fre_r <= 1'b1;
      else if (sts_rd)
        fre_r <= 1'b0;
    end
  end

  assign rx_dma_req_o = ctrl2_r[SCS_C2_RXDMA] & rxne_r;
  assign tx_dma_req_o = ctrl2_r[SCS_C2_TXDMA] & txe_r;

  // Interrupt sources are levels, so a read-clear re-arms while the cause stays
  logic [2:0] irq_src;
  assign irq_src[SCS_IRQ_RX]  = ctrl2_r[SCS_C2_RXIE] & rxne_r;
  assign irq_src[SCS_IRQ_TX]  = ctrl2_r[SCS_C2_TXIE] & txe_r;
  assign irq_src[SCS_IRQ_ERR] = ctrl2_r[SCS_C2_ERRIE] &
                                (ovr_r | mf_r | crc_r | udr_r | fre_r);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      irq_sts_r <= 3'h0;
    else if (rd_fire & reg_hit(s_axi_araddr_i, SCS_OFS_IRQ_STS))
      irq_sts_r <= irq_src;
    else
      irq_sts_r <= irq_sts_r | irq_src;
  end

  assign irq_o = |(irq_sts_r & irq_mask_r);

  // Write channel: address and data taken in either order
  assign s_axi_awready_o = ~aw_got_r;
  assign s_axi_wready_o  = ~w_got_r;
  assign wr_fire = aw_got_r & w_got_r & ~s_axi_bvalid_o;
  assign data_wr = wr_fire & reg_hit(awaddr_r, SCS_OFS_DATA);
  assign sts_wr  = wr_fire & reg_hit(awaddr_r, SCS_OFS_STATUS);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      aw_got_r <= 1'b0;
      w_got_r  <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r  <= 32'h0000_0000;
      wstrb_r  <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid_i & ~aw_got_r)
      begin
        aw_got_r <= 1'b1;
        awaddr_r <= s_axi_awaddr_i;
      end
      else if (wr_fire)
        aw_got_r <= 1'b0;
      if (s_axi_wvalid_i & ~w_got_r)
      begin
        w_got_r <= 1'b1;
        wdata_r <= s_axi_wdata_i;
        wstrb_r <= s_axi_wstrb_i;
      end
      else if (wr_fire)
        w_got_r <= 1'b0;
    end
  end

  logic wr_known;
  assign wr_known = reg_hit(awaddr_r, SCS_OFS_CTRL2) | reg_hit(awaddr_r, SCS_OFS_STATUS) |
                    reg_hit(awaddr_r, SCS_OFS_DATA) | reg_hit(awaddr_r, SCS_OFS_IRQ_STS) |
                    reg_hit(awaddr_r, SCS_OFS_IRQ_MASK) | reg_hit(awaddr_r, SCS_OFS_CONFIG);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o  <= SCS_RESP_OKAY;
    end
    else if (wr_fire)
    begin
      s_axi_bvalid_o <= 1'b1;
      s_axi_bresp_o  <= wr_known ? SCS_RESP_OKAY : SCS_RESP_SLVERR;
    end
    else if (s_axi_bready_i)
      s_axi_bvalid_o <= 1'b0;
  end

  // Software-written control registers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl2_r    <= SCS_CTRL2_RST;
      irq_mask_r <= SCS_IRQ_MASK_RST;
      cfg_r      <= SCS_CONFIG_RST;
    end
    else if (wr_fire & wstrb_r[0])
    begin
      if (reg_hit(awaddr_r, SCS_OFS_CTRL2))
        ctrl2_r <= wdata_r[15:0] & SCS_CTRL2_WMASK;
      if (reg_hit(awaddr_r, SCS_OFS_IRQ_MASK))
        irq_mask_r <= wdata_r[2:0];
      if (reg_hit(awaddr_r, SCS_OFS_CONFIG))
        cfg_r <= wdata_r[3:0];
    end
  end

  // Read channel
  logic [15:0] sts_word;
  logic [15:0] rd_val;
  logic        rd_err;
  logic        side_rd;

  assign side_rd  = audio & ~cfg_r[SCS_CF_PCM] & side_r;
  assign sts_word = {7'h00, fre_r, active_r, ovr_r, mf_r, crc_r, udr_r,
                     side_rd, txe_r, rxne_r};
  assign s_axi_arready_o = ~s_axi_rvalid_o;
  assign rd_fire = s_axi_arvalid_i & s_axi_arready_o;
  assign data_rd = rd_fire & reg_hit(s_axi_araddr_i, SCS_OFS_DATA);
  assign sts_rd  = rd_fire & reg_hit(s_axi_araddr_i, SCS_OFS_STATUS);

  always_comb
  begin
    rd_val = 16'h0000;
    rd_err = 1'b0;
    if (reg_hit(s_axi_araddr_i, SCS_OFS_CTRL2))
      rd_val = ctrl2_r;
    else if (reg_hit(s_axi_araddr_i, SCS_OFS_STATUS))
      rd_val = sts_word;
    else if (reg_hit(s_axi_araddr_i, SCS_OFS_DATA))
      rd_val = rxbuf_r;
    else if (reg_hit(s_axi_araddr_i, SCS_OFS_IRQ_STS))
      rd_val = {13'h0000, irq_sts_r};
    else if (reg_hit(s_axi_araddr_i, SCS_OFS_IRQ_MASK))
      rd_val = {13'h0000, irq_mask_r};
    else if (reg_hit(s_axi_araddr_i, SCS_OFS_CONFIG))
      rd_val = {12'h000, cfg_r};
    else
      rd_err = 1'b1;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o  <= 32'h0000_0000;
      s_axi_rresp_o  <= SCS_RESP_OKAY;
    end
    else if (rd_fire)
    begin
      s_axi_rvalid_o <= 1'b1;
      s_axi_rdata_o  <= {16'h0000, rd_val};
      s_axi_rresp_o  <= rd_err ? SCS_RESP_SLVERR : SCS_RESP_OKAY;
    end
    else if (s_axi_rready_i)
      s_axi_rvalid_o <= 1'b0;
  end

  chk_rx_dma_req: assert property (@(posedge clk_i) disable iff (rst_i)
    ctrl2_r[SCS_C2_RXDMA] && $rose(rxne_r) |-> rx_dma_req_o)
    else $error("rx dma request missing");
  chk_tx_dma_req: assert property (@(posedge clk_i) disable iff (rst_i)
    ctrl2_r[SCS_C2_TXDMA] && $rose(txe_r) |-> tx_dma_req_o)
    else $error("tx dma request missing");
  chk_select_drive: assert property (@(posedge clk_i) disable iff (rst_i)
    ss_n_oe_o |-> master && !audio && !ss_n_o)
    else $error("select driven outside master");
  chk_error_irq: assert property (@(posedge clk_i) disable iff (rst_i)
    ctrl2_r[SCS_C2_ERRIE] && ovr_r |=> irq_sts_r[SCS_IRQ_ERR])
    else $error("error interrupt not raised");
  chk_rx_flag_set: assert property (@(posedge clk_i) disable iff (rst_i)
    word_done |=> rxne_r)
    else $error("receive flag not set");
  chk_tx_flag_clr: assert property (@(posedge clk_i) disable iff (rst_i)
    data_wr && !load |=> !txe_r)
    else $error("transmit flag not cleared");
  chk_underrun_clr: assert property (@(posedge clk_i) disable iff (rst_i)
    sts_wr && wstrb_r[0] && !wdata_r[SCS_ST_UDR] && !(load && audio) |=> !udr_r)
    else $error("underrun not cleared");
  chk_crc_set: assert property (@(posedge clk_i) disable iff (rst_i)
    crc_mismatch_i && !audio |=> crc_r)
    else $error("check mismatch not flagged");
  chk_overrun_set: assert property (@(posedge clk_i) disable iff (rst_i)
    word_done && rxne_r |=> ovr_r && $stable(rxbuf_r))
    else $error("overrun not flagged");
  chk_busy_read: assert property (@(posedge clk_i) disable iff (rst_i)
    sts_rd |=> s_axi_rdata_o[7] == $past(active_r))
    else $error("busy bit mismatch");
  chk_frame_err_clr: assert property (@(posedge clk_i) disable iff (rst_i)
    sts_rd && !fre_evt |=> !fre_r)
    else $error("frame error not cleared by read");
endmodule // scs_top

// File: tb/scs_peer.sv
// Behavioural remote serial master driving the slave engine of the block
`timescale 1ns/1ns
module scs_peer
(
  // Link pins
  output logic      sck_o,
  output logic      ss_n_o,
  output logic      mosi_o,
  input  wire logic miso_i
);
  initial
  begin
    sck_o = 1'b0;
    ss_n_o = 1'b1;
    mosi_o = 1'b0;
  end

  // Settle time covers the two-stage synchronisers inside the slave
  task automatic sel(input bit on);
    #3 ss_n_o = ~on;
    #400;
  endtask

  // Clock idles low between words; data set on the fall, taken on the rise
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--)
    begin
      mosi_o = tx[i];
      #80 sck_o = 1'b1;
      rx[i] = miso_i;
      #80 sck_o = 1'b0;
    end
    // Released data line must not keep looking valid
    #80 mosi_o = ~mosi_o;
  endtask
endmodule // scs_peer

// File: tb/spi_control_status_regs_tb.sv
// Self-checking bench for the control-two and status register block
`timescale 1ns/1ns
module spi_control_status_regs_tb;
  import scs_pkg::*;
  typedef struct packed {logic [3:0] cfg; logic [15:0] c2;
                         logic [15:0] rb; logic [2:0] pin;} scs_row_t;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  wstrb = 4'hf;
  logic        awvalid = 1'b0;
  logic        wvalid = 1'b0;
  logic        bready = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready = 1'b0;
  logic        crc_bad = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp, resp;
  logic [31:0] rdata, val;
  logic        sck, ss_n, ss_w, mosi, miso, miso_oe, miso_w, ss_out, ss_oe;
  logic        ff, rxq, txq, irq;
  logic [7:0]  got;
  int          n_fail = 0;
  int          comparisons = 0;
  scs_row_t    rows [5];

  always #5 clk_i = ~clk_i;

  // Select pin is shared: the block wins while it drives
  assign ss_w = ss_oe ? ss_out : ss_n;
  // Released line shows the inverse so a stale bit cannot pass
  assign miso_w = miso_oe ? miso : ~miso;

  scs_top u_dut (.clk_i(clk_i), .rst_i(rst_i),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .sck_i(sck), .ss_n_i(ss_w),
    .ss_n_o(ss_out), .ss_n_oe_o(ss_oe), .mosi_i(mosi), .miso_o(miso), .miso_oe_o(miso_oe),
    .crc_mismatch_i(crc_bad), .frame_format_o(ff), .rx_dma_req_o(rxq),
    .tx_dma_req_o(txq), .irq_o(irq));

  scs_peer u_peer (.sck_o(sck), .ss_n_o(ss_n), .mosi_o(mosi), .miso_i(miso_w));

  task automatic close_out();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [3:0] s = 4'hf);
    int k;
    @(posedge clk_i);
    awaddr <= a;
    wdata <= {16'h0, d};
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (k = 0; k < 50; k++)
    begin
      @(posedge clk_i);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
      if (bvalid)
        break;
    end
    resp = bresp;
    bready <= 1'b0;
    if (k == 50)
    begin
      n_fail++;
      close_out();
    end
  endtask

  task automatic rd(input logic [7:0] a);
    int k;
    @(posedge clk_i);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (k = 0; k < 50; k++)
    begin
      @(posedge clk_i);
      if (arready)
        arvalid <= 1'b0;
      if (rvalid)
        break;
    end
    val = rdata;
    resp = rresp;
    rready <= 1'b0;
    if (k == 50)
    begin
      n_fail++;
      close_out();
    end
  endtask

  initial
  begin
    rows[0] = '{4'h0, 16'h0002, 16'h0002, 3'b010};
    rows[1] = '{4'h0, 16'h0010, 16'h0010, 3'b100};
    rows[2] = '{4'h3, 16'h0014, 16'h0014, 3'b000};
    rows[3] = '{4'h1, 16'h0004, 16'h0004, 3'b001};
    rows[4] = '{4'h0, 16'hffff, 16'h00f7, 3'b110};
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(SCS_OFS_STATUS);
    chk("status reset", val, 32'h2);
    rd(SCS_OFS_CTRL2);
    chk("ctrl2 reset", val, 32'h0);
    chk("pins reset", {29'h0, rxq, txq, irq}, 32'h0);
    rd(SCS_OFS_IRQ_MASK);
    chk("mask reset", val, 32'h7);
    for (int i = 0; i < 5; i++)
    begin
      wr(SCS_OFS_CONFIG, {12'h0, rows[i].cfg});
      wr(SCS_OFS_CTRL2, rows[i].c2);
      rd(SCS_OFS_CTRL2);
      chk("ctrl2", val, {16'h0, rows[i].rb});
      chk("pins", {29'h0, ff, txq, ss_oe}, {29'h0, rows[i].pin});
    end
    // Low byte lane off leaves the register alone
    wr(SCS_OFS_CTRL2, 16'h0000, 4'he);
    rd(SCS_OFS_CTRL2);
    chk("ctrl2 strobe", val, 32'hf7);
    wr(SCS_OFS_CTRL2, 16'h0041);
    // Clear the transmit-empty bit left sticky by the row loop
    rd(SCS_OFS_IRQ_STS);
    chk("irq sticky", val, 32'h2);
    chk("irq cleared", {31'h0, irq}, 32'h0);
    wr(SCS_OFS_DATA, 16'h00a5);
    rd(SCS_OFS_STATUS);
    chk("status loaded", val, 32'h0);
    u_peer.sel(1'b1);
    rd(SCS_OFS_STATUS);
    chk("status busy", val, 32'h82);
    u_peer.xfer(8'h3c, got);
    chk("miso word", {24'h0, got}, 32'ha5);
    repeat (5) @(posedge clk_i);
    rd(SCS_OFS_STATUS);
    chk("status rx", val, 32'h83);
    chk("rx req irq", {30'h0, rxq, irq}, 32'h3);
    // Second word while unread forces an overrun
    u_peer.xfer(8'h5a, got);
    repeat (5) @(posedge clk_i);
    wr(SCS_OFS_CTRL2, 16'h0061);
    rd(SCS_OFS_STATUS);
    chk("status ovr", val, 32'hc3);
    u_peer.sel(1'b0);
    rd(SCS_OFS_DATA);
    chk("rx data", val, 32'h3c);
    rd(SCS_OFS_STATUS);
    chk("status read", val, 32'h42);
    rd(SCS_OFS_IRQ_STS);
    chk("irq sts", val, 32'h5);
    repeat (2) @(posedge clk_i);
    chk("irq err", {31'h0, irq}, 32'h1);
    wr(SCS_OFS_IRQ_MASK, 16'h0003);
    chk("irq masked", {31'h0, irq}, 32'h0);
    wr(SCS_OFS_IRQ_MASK, 16'h0007);
    wr(SCS_OFS_STATUS, 16'h0000);
    rd(SCS_OFS_STATUS);
    chk("ovr clear", val, 32'h2);
    rd(SCS_OFS_IRQ_STS);
    repeat (2) @(posedge clk_i);
    chk("irq gone", {31'h0, irq}, 32'h0);
    @(posedge clk_i);
    crc_bad <= 1'b1;
    @(posedge clk_i);
    crc_bad <= 1'b0;
    rd(SCS_OFS_STATUS);
    chk("crc set", val, 32'h12);
    wr(SCS_OFS_STATUS, 16'h0010);
    rd(SCS_OFS_STATUS);
    chk("crc kept", val, 32'h12);
    wr(SCS_OFS_STATUS, 16'h0000);
    rd(SCS_OFS_STATUS);
    chk("crc clear", val, 32'h2);
    // Master without select drive while select pulled low
    wr(SCS_OFS_CONFIG, 16'h0001);
    wr(SCS_OFS_CTRL2, 16'h0000);
    u_peer.sel(1'b1);
    rd(SCS_OFS_STATUS);
    chk("fault set", val, 32'h22);
    chk("select off", {31'h0, ss_oe}, 32'h0);
    u_peer.sel(1'b0);
    wr(SCS_OFS_STATUS, 16'h0000);
    rd(SCS_OFS_STATUS);
    chk("fault clear", val, 32'h2);
    rd(8'h30);
    chk("unmapped rd", {resp, val[29:0]}, {SCS_RESP_SLVERR, 30'h0});
    wr(8'h30, 16'h1234);
    chk("unmapped wr", {30'h0, resp}, {30'h0, SCS_RESP_SLVERR});
    // Reset again in mid-run
    wr(SCS_OFS_CTRL2, 16'h00ff);
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(SCS_OFS_CTRL2);
    chk("ctrl2 rerst", val, 32'h0);
    rd(SCS_OFS_STATUS);
    chk("status rerst", val, 32'h2);
    // Audio slave: first word-select change starts a word with nothing queued
    wr(SCS_OFS_CONFIG, 16'h0002);
    u_peer.xfer(8'h00, got);
    repeat (5) @(posedge clk_i);
    rd(SCS_OFS_STATUS);
    chk("audio right", val, 32'h8e);
    chk("miso drive", {31'h0, miso_oe}, 32'h1);
    // Word select moving mid-word is a frame error
    u_peer.sel(1'b1);
    u_peer.xfer(8'h00, got);
    repeat (5) @(posedge clk_i);
    rd(SCS_OFS_STATUS);
    chk("frame error", val, 32'h18a);
    rd(SCS_OFS_STATUS);
    chk("frame err read", val, 32'h8a);
    wr(SCS_OFS_STATUS, 16'h0000);
    rd(SCS_OFS_STATUS);
    chk("udr clear", val, 32'h82);
    close_out();
  end
endmodule // spi_control_status_regs_tb
